// >>> alrt_pkg.sv
/*
 * Constants and carrier types for the alert limit and identification
 * register bank of a current and power monitor.
 * Assumes a serial front end that turns bus frames into register strobes.
 */
package alrt_pkg;

   // Register offsets as seen by the serial front end.
   localparam logic [7:0] ALRT_OFS_MASK_ENABLE = 8'h06;
   localparam logic [7:0] ALRT_OFS_THRESHOLD   = 8'h07;
   localparam logic [7:0] ALRT_OFS_MAKER_ID    = 8'hFE;
   localparam logic [7:0] ALRT_OFS_DIE_IDENTIFIER      = 8'hFF;

   // Field positions of the mask/enable register.
   localparam int ALRT_BIT_SENSE_OVER  = 15;
   localparam int ALRT_BIT_SENSE_UNDER = 14;
   localparam int ALRT_BIT_BUS_OVER    = 13;
   localparam int ALRT_BIT_BUS_UNDER   = 12;
   localparam int ALRT_BIT_POWER_OVER  = 11;
   localparam int ALRT_BIT_CONV_READY  = 10;
   localparam int ALRT_BIT_SRC_FLAG    = 4;
   localparam int ALRT_BIT_READY_FLAG  = 3;
   localparam int ALRT_BIT_OVF_FLAG    = 2;
   localparam int ALRT_BIT_POLARITY    = 1;
   localparam int ALRT_BIT_LATCH       = 0;

   // Field positions of the die identification register.
   localparam int ALRT_DIE_DEV_LSB = 4;
   localparam int ALRT_DIE_REV_LSB = 0;

   // Reset values.
   localparam logic [15:0] ALRT_THRESHOLD_RST = 16'h0000;
   localparam logic [15:0] ALRT_ZERO16        = 16'h0000;

   // Limit comparison selects, one bit each.
   typedef struct packed {
      logic sense_over_limit_select;
      logic sense_under_limit_select;
      logic bus_over_limit_select;
      logic bus_under_limit_select;
      logic power_over_limit_select;
   } alrt_select_s;

   // Measurements delivered by the conversion engine.
   typedef struct packed {
      logic [15:0] sense_value;
      logic [15:0] bus_value;
      logic [15:0] power_value;
   } alrt_meas_s;

   // Register strobes from the serial front end.
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } alrt_reg_req_s;

endpackage

// >>> alrt_limit_cmp.sv
/*
 * Limit comparator: tests the selected measurement against the threshold.
 * Assumes at most one select is meant to be set; the highest bit wins.
 */
`timescale 1ns/10ps
module alrt_limit_cmp
   import alrt_pkg::*;
(
   input  wire alrt_select_s sel_i,
   input  wire alrt_meas_s   meas_i,
   input  wire logic [15:0]  threshold_i,
   output logic              fault_o
);

   ////////////////////////////////////////////////////////////////////////
   // Sense voltage is two's complement; bus voltage and power are not.
   always_comb begin
      fault_o = 1'b0;
      if (sel_i.sense_over_limit_select) begin
         fault_o = $signed(meas_i.sense_value) > $signed(threshold_i);
      end else if (sel_i.sense_under_limit_select) begin
         fault_o = $signed(meas_i.sense_value) < $signed(threshold_i);
      end else if (sel_i.bus_over_limit_select) begin
         fault_o = meas_i.bus_value > threshold_i;
      end else if (sel_i.bus_under_limit_select) begin
         fault_o = meas_i.bus_value < threshold_i;
      end else if (sel_i.power_over_limit_select) begin
         fault_o = meas_i.power_value > threshold_i;
      end
   end

endmodule  // alrt_limit_cmp

// >>> alrt_limit_bank.sv
/*
 * Alert latching, limit register and identification registers.
 * Assumes register strobes synchronous to clk_i, one per cycle, and a
 * conversion-done pulse with measurements valid in that same cycle.
 */
`timescale 1ns/10ps
// Overview of operation
// - Latch select bit: one latches, zero transparent.
// - Transparent: alert idles once fault clears.
// - Latched: alert holds until mask/enable read.
// - 16-bit threshold at 07h compared to measurement.
// - Maker identifier, 16 bits, read at FEh.
// - Device identifier in bits 15:4 at FFh.
// - Die revision in bits 3:0 at FFh.
// - Selected measurement beyond threshold raises alert.
// - Alert active low, active high when polarity set.

module alrt_limit_bank
   import alrt_pkg::*;
#(
   parameter int          DATA_W     = 16,
   parameter logic [15:0] MAKER_ID   = 16'hA5C3,  // Arbitrary value.
   parameter logic [11:0] DEVICE_ID  = 12'h3B7,   // Arbitrary value.
   parameter logic [3:0]  REVISION   = 4'h1       // Arbitrary value.
)
(
   input  wire logic          clk_i,
   input  wire logic          nrst_i,
   input  wire logic          ce_i,
   input  wire alrt_reg_req_s req_i,
   input  wire alrt_meas_s    meas_i,
   input  wire logic          conv_done_i,
   input  wire logic          math_overflow_i,
   input  wire logic          cfg_write_i,
   output logic [15:0]        rd_data_o,
   output logic               rd_valid_o,
   output logic               alert_o,
   output logic               alert_oe_n_o,
   output logic [15:0]        threshold_o
);

   ////////////////////////////////////////////////////////////////////////
   // Elaboration check: the register file is built for 16-bit words only.
   // Other widths would need a reworked mask/enable layout.
   if (DATA_W != 16) begin : g_bad_width
      $error("alrt_limit_bank supports DATA_W of 16 only.");
   end

   ////////////////////////////////////////////////////////////////////////
   // Whole state of the block.
   // Read data and the pin enable sit in it, so both come from flops.
   typedef struct packed {
      logic [15:0]  threshold;
      alrt_select_s sel;
      logic         conv_ready_en;
      logic         polarity;
      logic         latch;
      logic         src_flag;
      logic         ready_flag;
      logic         ovf_flag;
      logic [15:0]  rd_data;
      logic         rd_valid;
      logic         alert_oe_n;
   } alrt_state_s;

   alrt_state_s state;
   alrt_state_s next_state;
   logic        fault;
   logic        mask_read;
   logic        mask_write;
   logic        alert_active;
   logic [15:0] mask_word;

   ////////////////////////////////////////////////////////////////////////
   // Comparator on the currently stored threshold and selects.
   // Its result is only acted upon in a cycle with conv_done_i high.
   alrt_limit_cmp u_cmp (
      .sel_i       (state.sel),
      .meas_i      (meas_i),
      .threshold_i (state.threshold),
      .fault_o     (fault)
   );

   ////////////////////////////////////////////////////////////////////////
   // Decoded strobes and the mask/enable word as read back.
   assign mask_read  = req_i.rd && (req_i.addr == ALRT_OFS_MASK_ENABLE);
   assign mask_write = req_i.wr && (req_i.addr == ALRT_OFS_MASK_ENABLE);

   always_comb begin
      mask_word = ALRT_ZERO16;
      mask_word[ALRT_BIT_SENSE_OVER]  = state.sel.sense_over_limit_select;
      mask_word[ALRT_BIT_SENSE_UNDER] = state.sel.sense_under_limit_select;
      mask_word[ALRT_BIT_BUS_OVER]    = state.sel.bus_over_limit_select;
      mask_word[ALRT_BIT_BUS_UNDER]   = state.sel.bus_under_limit_select;
      mask_word[ALRT_BIT_POWER_OVER]  = state.sel.power_over_limit_select;
      mask_word[ALRT_BIT_CONV_READY]  = state.conv_ready_en;
      mask_word[ALRT_BIT_SRC_FLAG]    = state.src_flag;
      mask_word[ALRT_BIT_READY_FLAG]  = state.ready_flag;
      mask_word[ALRT_BIT_OVF_FLAG]    = state.ovf_flag;
      mask_word[ALRT_BIT_POLARITY]    = state.polarity;
      mask_word[ALRT_BIT_LATCH]       = state.latch;
   end

   // The source flag is shared by all limit selects; one is meant at once.
   // The pin is active on a source flag, or on ready when that is enabled.
   assign alert_active = state.src_flag
                       | (state.conv_ready_en & state.ready_flag);

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic for registers, flags, read data and the pin.
   always_comb begin
      next_state          = state;
      next_state.rd_valid = 1'b0;

      // Register writes; identification offsets fall through untouched.
      if (req_i.wr) begin
         case (req_i.addr)
            ALRT_OFS_THRESHOLD: begin
               next_state.threshold = req_i.wdata;
            end
            ALRT_OFS_MASK_ENABLE: begin
               next_state.sel.sense_over_limit_select  =
                  req_i.wdata[ALRT_BIT_SENSE_OVER];
               next_state.sel.sense_under_limit_select =
                  req_i.wdata[ALRT_BIT_SENSE_UNDER];
               next_state.sel.bus_over_limit_select    =
                  req_i.wdata[ALRT_BIT_BUS_OVER];
               next_state.sel.bus_under_limit_select   =
                  req_i.wdata[ALRT_BIT_BUS_UNDER];
               next_state.sel.power_over_limit_select  =
                  req_i.wdata[ALRT_BIT_POWER_OVER];
               next_state.conv_ready_en = req_i.wdata[ALRT_BIT_CONV_READY];
               next_state.polarity = req_i.wdata[ALRT_BIT_POLARITY];
               next_state.latch    = req_i.wdata[ALRT_BIT_LATCH];
            end
            default: begin
               // Identification offsets are read-only; nothing is stored.
               next_state.threshold = state.threshold;
            end
         endcase
      end

      // Register reads answer one cycle later; unmapped reads give zero.
      // A read together with a write returns the value held before it.
      if (req_i.rd) begin
         next_state.rd_valid = 1'b1;
         case (req_i.addr)
            ALRT_OFS_THRESHOLD:   next_state.rd_data = state.threshold;
            ALRT_OFS_MASK_ENABLE: next_state.rd_data = mask_word;
            ALRT_OFS_MAKER_ID:    next_state.rd_data = MAKER_ID;
            ALRT_OFS_DIE_IDENTIFIER: begin
               next_state.rd_data = ALRT_ZERO16;
               next_state.rd_data[ALRT_DIE_DEV_LSB +: 12] = DEVICE_ID;
               next_state.rd_data[ALRT_DIE_REV_LSB +: 4] = REVISION;
            end
            default:              next_state.rd_data = ALRT_ZERO16;
         endcase
      end

      // Ready flag: cleared by a mask read or a configuration write,
      // and a conversion finishing in the same cycle wins.
      // With the ready alert enabled the flag also drives the pin.
      if (mask_read || cfg_write_i) begin
         next_state.ready_flag = 1'b0;
      end
      if (conv_done_i) begin
         next_state.ready_flag = 1'b1;
      end

      // Overflow flag follows the math engine at each conversion.
      if (conv_done_i) begin
         next_state.ovf_flag = math_overflow_i;
      end

      // Source flag: latched mode clears on a mask read only; transparent
      // mode follows each conversion result. A fault beats the clear.
      if (state.latch) begin
         if (mask_read) begin
            next_state.src_flag = 1'b0;
         end
      end else if (conv_done_i) begin
         next_state.src_flag = 1'b0;
      end
      if (conv_done_i && fault) begin
         next_state.src_flag = 1'b1;
      end

      // A mask/enable write holds the pin for that cycle, so that a
      // polarity change cannot glitch the pin through a stale level.
      // Open-drain pin: pull low when the asserted level is low.
      next_state.alert_oe_n = ~(alert_active ^ state.polarity);
      if (mask_write) begin
         next_state.alert_oe_n = state.alert_oe_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register with synchronous reset and clock enable.
   // Clock enable low freezes everything except the reset.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state                              <= '0;
         state.threshold                    <= ALRT_THRESHOLD_RST;
         state.latch                        <= 1'b0;
         state.polarity                     <= 1'b0;
         state.alert_oe_n                   <= 1'b1;
      end else if (ce_i) begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register.
   // The open-drain data line stays low; only its enable moves.
   assign rd_data_o    = state.rd_data;
   assign rd_valid_o   = state.rd_valid;
   assign alert_o      = 1'b0;
   assign alert_oe_n_o = state.alert_oe_n;
   assign threshold_o  = state.threshold;

endmodule  // alrt_limit_bank

// >>> alrt_bank_assertions.sv
/* Port checker for the alert limit bank.
   Assumes it is bound to alrt_limit_bank. */
`timescale 1ns/10ps
module alrt_bank_chk
   import alrt_pkg::*;
#(
   parameter logic [15:0] MAKER_ID  = 16'hA5C3,
   parameter logic [11:0] DEVICE_ID = 12'h3B7,
   parameter logic [3:0]  REVISION  = 4'h1
)
(
   input wire logic          clk_i,
   input wire logic          nrst_i,
   input wire logic          ce_i,
   input wire alrt_reg_req_s req_i,
   input wire logic [15:0]   rd_data_o,
   input wire logic          rd_valid_o,
   input wire logic          alert_o,
   input wire logic          alert_oe_n_o,
   input wire logic [15:0]   threshold_o
);
////////////////////////////////////////
   // All checks sample the rising edge and rest in reset.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   logic rd_c;
   logic wr_c;
   // Accepted strobes.
   assign rd_c = ce_i && req_i.rd;
   assign wr_c = ce_i && req_i.wr;
   a_read_answer: assert property (rd_c |=> rd_valid_o)
      else $error("read not answered");
   a_valid_no_read: assert property (
      ce_i && !req_i.rd |=> !rd_valid_o) else $error("stray read valid");
   a_maker_read: assert property (
      rd_c && req_i.addr == ALRT_OFS_MAKER_ID |=> rd_data_o == MAKER_ID)
      else $error("maker id wrong");
   a_device_field: assert property (
      rd_c && req_i.addr == ALRT_OFS_DIE_IDENTIFIER |=> rd_data_o[15:4] == DEVICE_ID)
      else $error("device id wrong");
   a_revision_field: assert property (
      rd_c && req_i.addr == ALRT_OFS_DIE_IDENTIFIER |=> rd_data_o[3:0] == REVISION)
      else $error("revision wrong");
   a_limit_write: assert property (
      wr_c && req_i.addr == ALRT_OFS_THRESHOLD
      |=> threshold_o == $past(req_i.wdata)) else $error("limit write lost");
   a_limit_read: assert property (
      rd_c && req_i.addr == ALRT_OFS_THRESHOLD
      |=> rd_data_o == $past(threshold_o)) else $error("limit read wrong");
   a_id_write_kept: assert property (
      wr_c && req_i.addr >= ALRT_OFS_MAKER_ID |=> $stable(threshold_o))
      else $error("id write leaked");
   a_pin_low_only: assert property (alert_o == 1'b0)
      else $error("alert data not low");
   a_reset_values: assert property ($rose(nrst_i) && $past(ce_i)
      |-> alert_oe_n_o && threshold_o == ALRT_THRESHOLD_RST && !rd_valid_o)
      else $error("reset values wrong");
endmodule // alrt_bank_chk

bind alrt_limit_bank alrt_bank_chk #(.MAKER_ID(MAKER_ID),
   .DEVICE_ID(DEVICE_ID), .REVISION(REVISION)) u_chk (.clk_i(clk_i),
   .nrst_i(nrst_i), .ce_i(ce_i), .req_i(req_i), .rd_data_o(rd_data_o),
   .rd_valid_o(rd_valid_o), .alert_o(alert_o),
   .alert_oe_n_o(alert_oe_n_o), .threshold_o(threshold_o));

// >>> alrt_host_model.sv
/* Host model issuing register strobes.
   Assumes a one-cycle read latency. */
`timescale 1ns/10ps
module alrt_host_model
   import alrt_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rd_valid_i,
   input  wire logic [15:0] rd_data_i,
   output alrt_reg_req_s    req_o
);
////////////////////////////////////////
   // Idle strobes; released qualifiers are inverted, not held.
   initial req_o = '0;
   // One write strobe.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i) #1 req_o = '{1'b1, 1'b0, a, d};
      @(posedge clk_i) #1 req_o = '{1'b0, 1'b0, ~a, ~d};
   endtask
   // One read strobe; the answer is sampled once, one cycle later.
   task automatic rd(input logic [7:0] a, output logic [15:0] d,
                     output logic ok);
      @(posedge clk_i) #1 req_o = '{1'b0, 1'b1, a, 16'hFFFF};
      @(posedge clk_i) #1 req_o = '{1'b0, 1'b0, ~a, 16'h0000};
      ok = rd_valid_i === 1'b1;
      d = rd_data_i;
   endtask
endmodule // alrt_host_model

// >>> tb.sv
/* Self-checking bench for alrt_limit_bank.
   Assumes the host model and bound checker. */
`timescale 1ns/10ps
module tb;
   import alrt_pkg::*;
   localparam logic [15:0] MK = 16'h5A3C; // Arbitrary value.
   localparam logic [11:0] DV = 12'h6D2;  // Arbitrary value.
   localparam logic [3:0]  RV = 4'h9;     // Arbitrary value.
   logic clk = 0, nrst = 0, ce = 1, conv_d = 0, ovf = 0, cfgw = 0;
   logic lo, val, pin;
   logic [15:0] rdat, thr, t;
   alrt_meas_s meas = '0;
   alrt_reg_req_s req;
   int fail_count = 0, checked = 0;
////////////////////////////////////////
   // Clock of 100 ns period.
   always #50 clk = ~clk;
   alrt_host_model i_alrt_host_model (.clk_i(clk), .rd_valid_i(val),
      .rd_data_i(rdat), .req_o(req));
   alrt_limit_bank #(.MAKER_ID(MK), .DEVICE_ID(DV), .REVISION(RV))
      i_alrt_limit_bank (.clk_i(clk), .nrst_i(nrst), .ce_i(ce),
      .req_i(req), .meas_i(meas), .conv_done_i(conv_d),
      .math_overflow_i(ovf), .cfg_write_i(cfgw), .rd_data_o(rdat),
      .rd_valid_o(val), .alert_o(lo), .alert_oe_n_o(pin),
      .threshold_o(thr));
   // Prints the counts and the verdict.
   task automatic wrap_up();
      $display("checked %0d failed %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input string nm, input logic [15:0] s, e);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [15:0] e,
                        input string nm);
      logic [15:0] d;
      logic ok;
      i_alrt_host_model.rd(a, d, ok);
      if (!ok) begin
         fail_count++;
         wrap_up();
      end else begin
         check(nm, d, e);
      end
   endtask
   // One conversion; returns two edges later when the pin has moved.
   task automatic conv(input logic [15:0] v);
      @(posedge clk) #1 meas = '{v, v, v};
      conv_d = 1'b1;
      ovf = 1'($urandom);
      @(posedge clk) #1 conv_d = 1'b0;
      meas = ~meas;
      @(posedge clk) #1;
   endtask
   // Expected mask/enable read: source flag s, ready flag r, last overflow.
   function automatic logic [15:0] flags(input logic [15:0] m,
                                         input logic s, r);
      return m | {11'h000, s, r, ovf, 2'b00};
   endfunction
   // Main sequence.
   initial begin
      void'($urandom(29917));
      repeat (8) @(posedge clk);
      #1 nrst = 1;
      rdchk(ALRT_OFS_THRESHOLD, ALRT_THRESHOLD_RST, "limit");
      rdchk(ALRT_OFS_MASK_ENABLE, ALRT_ZERO16, "mask");
      check("pin", pin, 16'h0001);
      repeat (20) begin
         t = 16'($urandom);
         i_alrt_host_model.wr(ALRT_OFS_THRESHOLD, t);
         i_alrt_host_model.wr(ALRT_OFS_MAKER_ID, ~t);
         i_alrt_host_model.wr(ALRT_OFS_DIE_IDENTIFIER, t);
         rdchk(ALRT_OFS_THRESHOLD, t, "limit");
         rdchk(ALRT_OFS_MAKER_ID, MK, "maker");
         rdchk(ALRT_OFS_DIE_IDENTIFIER, {DV, RV}, "die");
         rdchk(8'h10 + 8'($urandom % 200), ALRT_ZERO16, "unmapped");
      end
      $display("test registers done");
      i_alrt_host_model.wr(ALRT_OFS_THRESHOLD, 16'h0100);
      for (int b = 11; b <= 15; b++) begin
         i_alrt_host_model.wr(ALRT_OFS_MASK_ENABLE, 16'h0001 << b);
         conv((b == 12 || b == 14) ? 16'h0050 : 16'h0200);
         check("pin set", pin, 16'h0000);
         conv(16'h0100);
         check("pin clear", pin, 16'h0001);
      end
      $display("test transparent done");
      i_alrt_host_model.wr(ALRT_OFS_MASK_ENABLE, 16'h2001);
      conv(16'h0200);
      conv(16'h0100);
      check("pin held", pin, 16'h0000);
      rdchk(ALRT_OFS_MASK_ENABLE, flags(16'h2001, 1, 1), "mask");
      @(posedge clk) #1;
      check("pin freed", pin, 16'h0001);
      rdchk(ALRT_OFS_MASK_ENABLE, flags(16'h2001, 0, 0), "mask");
      $display("test latched done");
      i_alrt_host_model.wr(ALRT_OFS_MASK_ENABLE, 16'h2002);
      conv(16'h0100);
      check("inv idle", pin, 16'h0000);
      conv(16'h0200);
      check("inv active", pin, 16'h0001);
      $display("test polarity done");
      // Ready alert: cleared once by a mask read, once by a config write.
      i_alrt_host_model.wr(ALRT_OFS_MASK_ENABLE, 16'h0400);
      conv(16'h0000);
      check("ready pin", pin, 16'h0000);
      rdchk(ALRT_OFS_MASK_ENABLE, flags(16'h0400, 0, 1), "ready");
      @(posedge clk) #1;
      check("ready freed", pin, 16'h0001);
      conv(16'h0000);
      @(posedge clk) #1 cfgw = 1'b1;
      @(posedge clk) #1 cfgw = 1'b0;
      @(posedge clk) #1;
      check("cfg clear", pin, 16'h0001);
      rdchk(ALRT_OFS_MASK_ENABLE, flags(16'h0400, 0, 0), "ready");
      $display("test ready done");
      ce = 0;
      i_alrt_host_model.wr(ALRT_OFS_THRESHOLD, 16'h1234);
      ce = 1;
      rdchk(ALRT_OFS_THRESHOLD, 16'h0100, "frozen");
      @(posedge clk) #1 nrst = 0;
      repeat (2) @(posedge clk);
      #1 nrst = 1;
      rdchk(ALRT_OFS_THRESHOLD, ALRT_THRESHOLD_RST, "limit");
      rdchk(ALRT_OFS_MASK_ENABLE, ALRT_ZERO16, "mask");
      check("pin", pin, 16'h0001);
      $display("test reset again done");
      wrap_up();
   end
endmodule // tb
